// [pkg/tmw_pkg.sv]
// Package for the 8-bit timer waveform block: modes, register offsets, reset values.
// Assumes a single core clock and a plain address/strobe register port.
package tmw_pkg;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    // Register offsets (byte index on the plain port)
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_COUNT = 3'h1;
    localparam logic [2:0] REG_CMPA = 3'h2;
    localparam logic [2:0] REG_CMPB = 3'h3;
    localparam logic [2:0] REG_FLAGS = 3'h4;
    // Control field positions
    localparam int CTRL_WGM_LSB = 0;
    localparam int CTRL_OMB_LSB = 4;
    localparam int CTRL_OMA_LSB = 6;
    // Flag positions
    localparam int FLAG_OVF = 0;
    localparam int FLAG_CMPA = 1;
    localparam int FLAG_CMPB = 2;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] WGM_NORMAL = 3'h0;
    localparam logic [2:0] WGM_PC_FF = 3'h1;
    localparam logic [2:0] WGM_CTC = 3'h2;
    localparam logic [2:0] WGM_FAST_FF = 3'h3;
    localparam logic [2:0] WGM_PC_OCR = 3'h5;
    localparam logic [2:0] WGM_FAST_OCR = 3'h7;
    localparam logic [1:0] OM_OFF = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR = 2'h2;
    localparam logic [1:0] OM_SET = 2'h3;

    typedef enum {SEQ_NORMAL, SEQ_CTC, SEQ_FAST, SEQ_PHASE} tmw_seq_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tmw_bus_req_t;

    typedef struct packed {
        logic outA;
        logic outB;
        logic enA;
        logic enB;
    } tmw_wave_t;
endpackage

// [core/tmw_timer8.sv]
// 8-bit timer/counter waveform generator with two compare channels.
// Assumes timerTick comes from an external prescaler; register port is synchronous.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module tmw_timer8 (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Timer tick from prescaler
    input wire logic timerTick,
    // Register port
    input wire tmw_pkg::tmw_bus_req_t busReq,
    output logic [7:0] rdData,
    // Waveform outputs
    output tmw_pkg::tmw_wave_t wave,
    // Flags, also readable
    output logic overflowFlag,
    output logic compareAFlag,
    output logic compareBFlag
);
    logic [7:0] ctrl_ff;
    logic [7:0] count_ff;
    logic [7:0] cmpABuf_ff;
    logic [7:0] cmpBBuf_ff;
    logic [7:0] cmpA_ff;
    logic [7:0] cmpB_ff;
    logic down_ff;
    logic block_ff;
    logic matchA_ff;
    logic matchB_ff;
    logic ovf_ff;
    logic flagA_ff;
    logic flagB_ff;
    logic outA_ff;
    logic outB_ff;
    logic [7:0] rdData_ff;
    logic [7:0] nxt_count;
    logic nxt_down;
    logic [2:0] wgm;
    logic [1:0] omA;
    logic [1:0] omB;
    tmw_pkg::tmw_seq_t seq;
    logic isPwm;
    logic [7:0] topVal;
    logic atTop;
    logic atBottom;
    logic matchA;
    logic matchB;
    logic wrCount;
    logic wrCmpA;
    logic wrCmpB;
    logic wrFlags;
    logic ovfSet;
    logic nxt_outA;
    logic nxt_outB;

    assign wgm = ctrl_ff[tmw_pkg::CTRL_WGM_LSB +: 3];
    assign omA = ctrl_ff[tmw_pkg::CTRL_OMA_LSB +: 2];
    assign omB = ctrl_ff[tmw_pkg::CTRL_OMB_LSB +: 2];
    assign wrCount = busReq.wr && busReq.addr == tmw_pkg::REG_COUNT;
    assign wrCmpA = busReq.wr && busReq.addr == tmw_pkg::REG_CMPA;
    assign wrCmpB = busReq.wr && busReq.addr == tmw_pkg::REG_CMPB;
    assign wrFlags = busReq.wr && busReq.addr == tmw_pkg::REG_FLAGS;

    // Counting sequence decoded from waveform mode only
    always_comb begin
        case (wgm)
            tmw_pkg::WGM_CTC: seq = tmw_pkg::SEQ_CTC;
            tmw_pkg::WGM_FAST_FF, tmw_pkg::WGM_FAST_OCR: seq = tmw_pkg::SEQ_FAST;
            tmw_pkg::WGM_PC_FF, tmw_pkg::WGM_PC_OCR: seq = tmw_pkg::SEQ_PHASE;
            // Reserved codes fall through to plain counting
            default: seq = tmw_pkg::SEQ_NORMAL;
        endcase
    end

    assign isPwm = seq == tmw_pkg::SEQ_FAST || seq == tmw_pkg::SEQ_PHASE;
    // PWM modes with bit 2 set take compare A as top
    assign topVal = (isPwm && wgm[2]) ? cmpA_ff : tmw_pkg::CNT_MAX;
    assign atTop = count_ff == topVal;
    assign atBottom = count_ff == tmw_pkg::CNT_BOTTOM;
    // Write to counter masks the compare for one timer tick
    assign matchA = count_ff == cmpA_ff && !block_ff;
    assign matchB = count_ff == cmpB_ff && !block_ff;

    // Next count and direction
    always_comb begin
        nxt_count = count_ff;
        nxt_down = down_ff;
        case (seq)
            tmw_pkg::SEQ_CTC: begin
                // Missed match simply wraps through 0xFF
                // A blocked match must not clear the count either
                nxt_count = matchA ? tmw_pkg::CNT_BOTTOM : count_ff + 8'h01;
                nxt_down = 1'b0;
            end
            tmw_pkg::SEQ_FAST: begin
                nxt_count = atTop ? tmw_pkg::CNT_BOTTOM : count_ff + 8'h01;
                nxt_down = 1'b0;
            end
            tmw_pkg::SEQ_PHASE: begin
                // Top held one tick, then descend
                if (atTop) begin
                    nxt_down = 1'b1;
                    nxt_count = count_ff - 8'h01;
                end else if (atBottom) begin
                    nxt_down = 1'b0;
                    nxt_count = count_ff + 8'h01;
                end else if (down_ff) begin
                    nxt_count = count_ff - 8'h01;
                end else begin
                    nxt_count = count_ff + 8'h01;
                end
                if (topVal == tmw_pkg::CNT_BOTTOM) begin
                    nxt_count = tmw_pkg::CNT_BOTTOM;
                end
            end
            default: begin
                nxt_count = count_ff + 8'h01;
                nxt_down = 1'b0;
            end
        endcase
    end

    // Counter: software write overrides counting
    always_ff @(posedge core_clk) begin
        if (rst) begin
            count_ff <= tmw_pkg::RST_BYTE;
            down_ff <= 1'b0;
        end else if (wrCount) begin
            count_ff <= busReq.wdata;
        end else if (timerTick) begin
            count_ff <= nxt_count;
            down_ff <= nxt_down;
        end
    end

    // Block stays until the next timer tick is consumed
    always_ff @(posedge core_clk) begin
        if (rst) begin
            block_ff <= 1'b0;
        end else if (wrCount) begin
            block_ff <= 1'b1;
        end else if (timerTick) begin
            block_ff <= 1'b0;
        end
    end

    // Compare buffers and active values
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmpABuf_ff <= tmw_pkg::RST_BYTE;
            cmpBBuf_ff <= tmw_pkg::RST_BYTE;
        end else begin
            if (wrCmpA) begin
                cmpABuf_ff <= busReq.wdata;
            end
            if (wrCmpB) begin
                cmpBBuf_ff <= busReq.wdata;
            end
        end
    end

    // Fast PWM loads at top, phase-correct at top as well for symmetry
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmpA_ff <= tmw_pkg::RST_BYTE;
            cmpB_ff <= tmw_pkg::RST_BYTE;
        end else if (!isPwm) begin
            // Direct writes here; PWM writes wait in the buffer
            if (wrCmpA) begin
                cmpA_ff <= busReq.wdata;
            end
            if (wrCmpB) begin
                cmpB_ff <= busReq.wdata;
            end
        end else if (timerTick && atTop) begin
            cmpA_ff <= cmpABuf_ff;
            cmpB_ff <= cmpBBuf_ff;
        end
    end

    // Overflow event per sequence
    always_comb begin
        case (seq)
            tmw_pkg::SEQ_FAST: ovfSet = atTop;
            tmw_pkg::SEQ_PHASE: ovfSet = atBottom;
            // Counter about to become zero from max
            default: ovfSet = count_ff == tmw_pkg::CNT_MAX;
        endcase
    end

    // Match registered, flag set on the following tick
    always_ff @(posedge core_clk) begin
        if (rst) begin
            matchA_ff <= 1'b0;
            matchB_ff <= 1'b0;
        end else if (timerTick) begin
            matchA_ff <= matchA;
            matchB_ff <= matchB;
        end else if (wrCount) begin
            // A pending match is dropped so no flag follows the write
            matchA_ff <= 1'b0;
            matchB_ff <= 1'b0;
        end
    end

    // Flags: write one clears, hardware set wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ovf_ff <= 1'b0;
            flagA_ff <= 1'b0;
            flagB_ff <= 1'b0;
        end else begin
            // Counter write overrides counting, so that tick brings no overflow
            ovf_ff <= (timerTick && ovfSet && !wrCount) ||
                      (ovf_ff && !(wrFlags && busReq.wdata[tmw_pkg::FLAG_OVF]));
            flagA_ff <= (timerTick && matchA_ff) ||
                        (flagA_ff && !(wrFlags && busReq.wdata[tmw_pkg::FLAG_CMPA]));
            flagB_ff <= (timerTick && matchB_ff) ||
                        (flagB_ff && !(wrFlags && busReq.wdata[tmw_pkg::FLAG_CMPB]));
        end
    end

    // Output A next level
    always_comb begin
        nxt_outA = outA_ff;
        if (seq == tmw_pkg::SEQ_FAST) begin
            if (omA == tmw_pkg::OM_TOGGLE) begin
                if (wgm[2] && matchA) begin
                    nxt_outA = !outA_ff;
                end
            end else if (omA[1]) begin
                // Match at top ignored so compare at top gives constant level
                if (atTop) begin
                    nxt_outA = !omA[0];
                end else if (matchA) begin
                    nxt_outA = omA[0];
                end
            end
        end else if (seq == tmw_pkg::SEQ_PHASE) begin
            if (omA == tmw_pkg::OM_TOGGLE) begin
                if (wgm[2] && matchA) begin
                    nxt_outA = !outA_ff;
                end
            end else if (omA[1]) begin
                // At top force the up-match level, or the down-match level if compare equals top; covers leaving top and late start
                if (atTop) begin
                    nxt_outA = (cmpA_ff == topVal) ? !omA[0] : omA[0];
                end else if (matchA && down_ff && !atBottom) begin
                    nxt_outA = !omA[0];
                end else if (matchA) begin
                    // Match at bottom acts as up-count, so compare zero stays at the up-match level
                    nxt_outA = omA[0];
                end
            end
        end else if (matchA) begin
            case (omA)
                tmw_pkg::OM_TOGGLE: nxt_outA = !outA_ff;
                tmw_pkg::OM_CLEAR: nxt_outA = 1'b0;
                tmw_pkg::OM_SET: nxt_outA = 1'b1;
                default: nxt_outA = outA_ff;
            endcase
        end
    end

    // Output B next level; toggle not offered in PWM
    always_comb begin
        nxt_outB = outB_ff;
        if (seq == tmw_pkg::SEQ_FAST) begin
            if (omB[1]) begin
                if (atTop) begin
                    nxt_outB = !omB[0];
                end else if (matchB) begin
                    nxt_outB = omB[0];
                end
            end
        end else if (seq == tmw_pkg::SEQ_PHASE) begin
            if (omB[1]) begin
                if (atTop) begin
                    nxt_outB = (cmpB_ff >= topVal) ? !omB[0] : omB[0];
                end else if (matchB && down_ff && !atBottom) begin
                    nxt_outB = !omB[0];
                end else if (matchB) begin
                    nxt_outB = omB[0];
                end
            end
        end else if (matchB) begin
            case (omB)
                tmw_pkg::OM_TOGGLE: nxt_outB = !outB_ff;
                tmw_pkg::OM_CLEAR: nxt_outB = 1'b0;
                tmw_pkg::OM_SET: nxt_outB = 1'b1;
                default: nxt_outB = outB_ff;
            endcase
        end
    end

    // Output registers keep state across mode changes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            outA_ff <= 1'b0;
            outB_ff <= 1'b0;
        end else if (timerTick) begin
            outA_ff <= nxt_outA;
            outB_ff <= nxt_outB;
        end
    end

    // Control register
    // Reserved bit 3 and waveform mode bit 2 are kept but read back as zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_ff <= tmw_pkg::RST_BYTE;
        end else if (busReq.wr && busReq.addr == tmw_pkg::REG_CTRL) begin
            ctrl_ff <= busReq.wdata;
        end
    end

    // Read data one cycle after strobe; buffered compare seen in PWM
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdData_ff <= 8'h00;
        end else if (busReq.rd) begin
            case (busReq.addr)
                tmw_pkg::REG_CTRL: rdData_ff <= ctrl_ff & 8'hf3;
                tmw_pkg::REG_COUNT: rdData_ff <= count_ff;
                tmw_pkg::REG_CMPA: rdData_ff <= isPwm ? cmpABuf_ff : cmpA_ff;
                tmw_pkg::REG_CMPB: rdData_ff <= isPwm ? cmpBBuf_ff : cmpB_ff;
                tmw_pkg::REG_FLAGS: rdData_ff <= {5'h00, flagB_ff, flagA_ff, ovf_ff};
                default: rdData_ff <= 8'h00;
            endcase
        end else begin
            // Idle cycles read zero so stale data never lingers
            rdData_ff <= 8'h00;
        end
    end

    assign rdData = rdData_ff;
    assign wave.outA = outA_ff;
    assign wave.outB = outB_ff;
    // Pin override only where the output mode offers an action
    assign wave.enA = omA != tmw_pkg::OM_OFF && !(isPwm && omA == tmw_pkg::OM_TOGGLE && !wgm[2]);
    assign wave.enB = omB != tmw_pkg::OM_OFF && !(isPwm && omB == tmw_pkg::OM_TOGGLE);
    // Sticky levels; software clears them by writing one
    assign overflowFlag = ovf_ff;
    assign compareAFlag = flagA_ff;
    assign compareBFlag = flagB_ff;
endmodule

// [bench/tmw_timer8_checker.sv]
// Port-level assertions for the 8-bit timer waveform block.
// Assumes the control byte map: waveform mode in [2:0], output mode B in [5:4], A in [7:6].
`timescale 1ns/1ps
module tmw_timer8_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Stimulus
    input wire logic timerTick,
    input wire tmw_pkg::tmw_bus_req_t busReq,
    // Observed
    input wire logic [7:0] rdData,
    input wire tmw_pkg::tmw_wave_t wave,
    input wire logic overflowFlag,
    input wire logic compareAFlag,
    input wire logic compareBFlag
);
    logic [7:0] ctrlCopy_ff;
    logic flagWr;
    logic pwmNoToggleA;
    logic pwmToggleB;
    // Shadow of the control byte, so mode-dependent rules can be judged
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrlCopy_ff <= 8'h00;
        end else if (busReq.wr && busReq.addr == tmw_pkg::REG_CTRL) begin
            ctrlCopy_ff <= busReq.wdata;
        end
    end
    assign flagWr = busReq.wr && busReq.addr == tmw_pkg::REG_FLAGS;
    assign pwmNoToggleA = ctrlCopy_ff[0] && !ctrlCopy_ff[2] && ctrlCopy_ff[7:6] == tmw_pkg::OM_TOGGLE;
    assign pwmToggleB = ctrlCopy_ff[0] && ctrlCopy_ff[5:4] == tmw_pkg::OM_TOGGLE;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_ENA_FOLLOWS: assert property (!pwmNoToggleA |-> wave.enA == (ctrlCopy_ff[7:6] != 2'h0))
        else $error("enable A does not follow output mode A");
    AST_ENB_FOLLOWS: assert property (!pwmToggleB |-> wave.enB == (ctrlCopy_ff[5:4] != 2'h0))
        else $error("enable B does not follow output mode B");
    AST_OVF_STICKY: assert property ($fell(overflowFlag) |-> $past(flagWr && busReq.wdata[0]) || $past(rst))
        else $error("overflow flag dropped without a clearing write");
    AST_CMPA_STICKY: assert property ($fell(compareAFlag) |-> $past(flagWr && busReq.wdata[1]) || $past(rst))
        else $error("compare A flag dropped without a clearing write");
    AST_OVF_ON_TICK: assert property ($rose(overflowFlag) |-> $past(timerTick))
        else $error("overflow flag set without a timer tick");
    AST_CMPB_ON_TICK: assert property ($rose(compareBFlag) |-> $past(timerTick))
        else $error("compare B flag set without a timer tick");
    AST_OUTA_ON_TICK: assert property ($changed(wave.outA) |-> $past(timerTick) || $past(rst))
        else $error("output A moved without a timer tick");
    AST_OUTB_NO_TOGGLE: assert property (pwmToggleB && $past(pwmToggleB) |-> $stable(wave.outB))
        else $error("output B toggled in a PWM mode");
    AST_OUTA_NO_TOGGLE: assert property (pwmNoToggleA && $past(pwmNoToggleA) |-> $stable(wave.outA))
        else $error("output A toggled with mode bit 2 clear");
endmodule
bind tmw_timer8 tmw_timer8_checker u_chk (.core_clk(core_clk), .rst(rst), .timerTick(timerTick),
    .busReq(busReq), .rdData(rdData), .wave(wave), .overflowFlag(overflowFlag),
    .compareAFlag(compareAFlag), .compareBFlag(compareBFlag));

// [bench/tmw_timer8_bench.sv]
// Self-checking bench for the 8-bit timer waveform block.
// Assumes the plain register port map; timer ticks are driven here, not by a prescaler.
`timescale 1ns/1ps
module tmw_timer8_bench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic timerTick = 1'b0;
    tmw_pkg::tmw_bus_req_t busReq = '0;
    logic [7:0] rdData;
    tmw_pkg::tmw_wave_t wave;
    logic overflowFlag;
    logic compareAFlag;
    logic compareBFlag;
    int n_fail = 0;
    int checks_done = 0;
    int hiA;
    int hiB;
    logic [7:0] d;
    tmw_timer8 uut (.core_clk(core_clk), .rst(rst), .timerTick(timerTick), .busReq(busReq), .rdData(rdData),
        .wave(wave), .overflowFlag(overflowFlag), .compareAFlag(compareAFlag), .compareBFlag(compareBFlag));
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] v);
        @(posedge core_clk);
        busReq <= '{a, v, 1'b1, 1'b0};
        @(posedge core_clk);
        busReq.wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(logic [2:0] a);
        @(posedge core_clk);
        busReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk);
        busReq.rd <= 1'b0;
        #1 d = rdData;
    endtask
    // Exactly n ticks; counts high output samples for duty figures
    task automatic run(int n);
        @(posedge core_clk);
        timerTick <= 1'b1;
        hiA = 0;
        hiB = 0;
        // Sampled at the falling edge, where the outputs have settled
        repeat (n) begin
            @(negedge core_clk);
            hiA += wave.outA;
            hiB += wave.outB;
        end
        @(posedge core_clk);
        timerTick <= 1'b0;
        #1;
    endtask
    task automatic t_reset();
        for (int a = 0; a < 8; a++) begin
            rd(3'(a));
            check("reset or unmapped read", d, 8'h00);
        end
        wr(3'h5, 8'hff);
        rd(3'h5);
        check("unmapped write", d, 8'h00);
        check("enables off", {wave.enA, wave.enB}, 2'h0);
        $display("test reset done");
    endtask
    task automatic t_normal();
        logic [2:0] m[3] = '{3'h0, 3'h4, 3'h6};
        foreach (m[i]) begin
            wr(tmw_pkg::REG_CTRL, {5'h00, m[i]});
            wr(tmw_pkg::REG_COUNT, 8'hfe);
            wr(tmw_pkg::REG_FLAGS, 8'h07);
            run(2);
            rd(tmw_pkg::REG_COUNT);
            check("count wrap", d, 8'h00);
            check("overflow set", overflowFlag, 1'b1);
            run(1);
            rd(tmw_pkg::REG_COUNT);
            check("count after wrap", d, 8'h01);
            check("overflow kept", overflowFlag, 1'b1);
        end
        $display("test normal done");
    endtask
    task automatic t_ctc();
        wr(tmw_pkg::REG_CTRL, 8'h72);
        wr(tmw_pkg::REG_CMPA, 8'h03);
        wr(tmw_pkg::REG_COUNT, 8'h00);
        wr(tmw_pkg::REG_FLAGS, 8'h07);
        run(5);
        rd(tmw_pkg::REG_COUNT);
        check("ctc count", d, 8'h01);
        check("ctc flag a", compareAFlag, 1'b1);
        check("ctc toggle a", {wave.outA, wave.enA}, 2'h3);
        check("ctc set b", {wave.outB, wave.enB}, 2'h3);
        check("ctc no overflow", overflowFlag, 1'b0);
        // Top written below the count: the match is missed once
        wr(tmw_pkg::REG_FLAGS, 8'h07);
        wr(tmw_pkg::REG_COUNT, 8'h10);
        wr(tmw_pkg::REG_CMPA, 8'h05);
        run(240);
        rd(tmw_pkg::REG_COUNT);
        check("ctc missed match", d, 8'h00);
        check("ctc overflow", overflowFlag, 1'b1);
        check("ctc no flag a", compareAFlag, 1'b0);
        wr(tmw_pkg::REG_CMPA, 8'h20);
        wr(tmw_pkg::REG_COUNT, 8'h20);
        wr(tmw_pkg::REG_FLAGS, 8'h07);
        run(1);
        rd(tmw_pkg::REG_COUNT);
        check("blocked clear", d, 8'h21);
        run(1);
        check("blocked flag", compareAFlag, 1'b0);
        $display("test ctc done");
    endtask
    task automatic t_fast();
        logic [7:0] c[3] = '{8'h00, 8'h80, 8'hff};
        wr(tmw_pkg::REG_CTRL, 8'hb3);
        foreach (c[i]) begin
            wr(tmw_pkg::REG_CMPA, c[i]);
            wr(tmw_pkg::REG_CMPB, c[i]);
            wr(tmw_pkg::REG_FLAGS, 8'h07);
            run(512);
            check("fast overflow", overflowFlag, 1'b1);
            check("fast flag b", compareBFlag, 1'b1);
            run(256);
            check("fast duty a", 16'(hiA), 16'(c[i]) + 16'h1);
            check("fast duty b", 16'(hiB), 16'h00ff - 16'(c[i]));
        end
        wr(tmw_pkg::REG_CTRL, 8'h67);
        wr(tmw_pkg::REG_CMPA, 8'h09);
        wr(tmw_pkg::REG_CMPB, 8'h04);
        run(300);
        run(20);
        check("fast toggle a", 16'(hiA), 16'd10);
        check("fast top a duty b", 16'(hiB), 16'd10);
        wr(tmw_pkg::REG_CTRL, 8'h53);
        run(300);
        check("no toggle", 16'((hiA % 300) + (hiB % 300)), 16'h0);
        $display("test fast done");
    endtask
    task automatic t_phase();
        logic [7:0] c[3] = '{8'h00, 8'h80, 8'hff};
        logic [15:0] e[3] = '{16'h0, 16'h100, 16'h1fe};
        wr(tmw_pkg::REG_CTRL, 8'hb1);
        foreach (c[i]) begin
            wr(tmw_pkg::REG_CMPA, c[i]);
            wr(tmw_pkg::REG_CMPB, c[i]);
            wr(tmw_pkg::REG_FLAGS, 8'h07);
            run(1020);
            check("phase overflow", overflowFlag, 1'b1);
            run(510);
            check("phase duty a", 16'(hiA), e[i]);
            check("phase duty b", 16'(hiB), 16'h1fe - e[i]);
        end
        // Top from compare A: A at top stays high, B at half of top runs half duty
        wr(tmw_pkg::REG_CTRL, 8'ha5);
        wr(tmw_pkg::REG_CMPA, 8'h10);
        wr(tmw_pkg::REG_CMPB, 8'h08);
        run(800);
        run(64);
        check("phase top a level", 16'(hiA), 16'd64);
        check("phase top a duty b", 16'(hiB), 16'd32);
        $display("test phase done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_normal();
        t_ctc();
        t_fast();
        t_phase();
        test_done();
    end
    // Whole sequence needs about 10k cycles
    initial begin
        repeat (30000) @(posedge core_clk);
        n_fail++;
        test_done();
    end
endmodule
